// ---- hw/spimem_consts.svh ----
// constants for the serial memory command block
`ifndef SPIMEM_CONSTS_SVH
`define SPIMEM_CONSTS_SVH
`define SPIMEM_OP_WRITE_ENABLE_CMD_CODE     8'h06
`define SPIMEM_OP_WRITE_DISABLE_CMD_CODE     8'h04
`define SPIMEM_OP_RDSTAT_CODE   8'h05
`define SPIMEM_OP_WRSTAT_CODE   8'h01
`define SPIMEM_OP_READ_CODE     8'h03
`define SPIMEM_OP_WRITE_CODE    8'h02
`define SPIMEM_OP_SLEEP_CODE    8'hb9
`define SPIMEM_OP_WAKE_CODE     8'hab
`define SPIMEM_BIT_SWP          7
`define SPIMEM_BIT_BPHI         3
`define SPIMEM_BIT_BPLO         2
`define SPIMEM_BIT_WEL          1
`define SPIMEM_STATUS_RESET     8'h00
`define SPIMEM_SLEEP_ENTRY_NS   3000
`define SPIMEM_SLEEP_EXIT_NS    400000
`define SPIMEM_CLK_NS           40
`define SPIMEM_SLEEP_ENTRY_CYC  ((`SPIMEM_SLEEP_ENTRY_NS + `SPIMEM_CLK_NS - 1) / `SPIMEM_CLK_NS)
`define SPIMEM_SLEEP_EXIT_CYC   ((`SPIMEM_SLEEP_EXIT_NS + `SPIMEM_CLK_NS - 1) / `SPIMEM_CLK_NS)
`endif

// ---- hw/spimem_pkg.sv ----
// types for the serial memory command block
package spimem_pkg;
    typedef enum logic [2:0] {
        SPIMEM_ST_OPCODE = 3'b000,
        SPIMEM_ST_ADDR   = 3'b001,
        SPIMEM_ST_RDATA  = 3'b010,
        SPIMEM_ST_WDATA  = 3'b011,
        SPIMEM_ST_SDATA  = 3'b100,
        SPIMEM_ST_STAT   = 3'b101,
        SPIMEM_ST_IGNORE = 3'b110
    } spimem_state_type;
    typedef enum logic [1:0] {
        SPIMEM_PW_AWAKE   = 2'b00,
        SPIMEM_PW_ENTER   = 2'b01,
        SPIMEM_PW_ASLEEP  = 2'b10,
        SPIMEM_PW_WAKING  = 2'b11
    } spimem_power_type;
endpackage

// ---- hw/spimem_core.sv ----
// spi target command engine of a byte serial memory, oversampling the spi pins
// Notes on behaviour
// - status byte readable only while awake
// - status bit 0 never changed by hardware
// - write enable opcode sets latch
// - status and array writes need latch set
// - write disable opcode clears latch
// - latch cleared at power up
// - status write needs latch and protect pass
// - status bits kept except the latch
// - sixteen bit address, top bit ignored
// - read streams successive bytes until deselect
// - address counter wraps to zero
// - write stores successive bytes until deselect
// - writes run at full rate, no busy
// - sleep opcode turns regulators off
// - asleep, only wake opcode acts
// - power loss in sleep yields standby
// - wake restores regulators at once, ready after recovery time
// - opcode values, read and write addressed
// - status bit positions fixed
// - block protect codes select protected range
// - sleep entry and exit minimum times
`timescale 1ns/1ps
`include "spimem_consts.svh"
module spimem_core #(
    parameter int ADDR_BITS    = 15,
    parameter int ENTRY_CYCLES = `SPIMEM_SLEEP_ENTRY_CYC,
    parameter int EXIT_CYCLES  = `SPIMEM_SLEEP_EXIT_CYC
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic wp_n,
    output logic      so_out,
    output logic      so_oe,
    output logic      regulators_on,
    output logic      ready
);
    localparam int DEPTH = 1 << ADDR_BITS;
    localparam int CW    = 19;
    logic [7:0] mem [DEPTH];
    // two-flop synchronisers, stage one read only by stage two
    logic [3:0] s1_q, s2_q, s3_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 4'hf;
            s2_q <= 4'hf;
            s3_q <= 4'hf;
        end else begin
            s1_q <= {wp_n, si, cs_n, sck};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    logic sck_s, cs_s, si_s, wp_s, rise, fall, cs_fall, cs_rise;
    assign sck_s   = s2_q[0];
    assign cs_s    = s2_q[1];
    assign si_s    = s2_q[2];
    assign wp_s    = s2_q[3];
    assign rise    = sck_s & ~s3_q[0] & ~cs_s;
    assign fall    = ~sck_s & s3_q[0] & ~cs_s;
    assign cs_fall = ~cs_s & s3_q[1];
    assign cs_rise = cs_s & ~s3_q[1];
    // two-entry buffer between the byte shifter and the array write port
    logic [7:0]           wb_data_q [2];
    logic [ADDR_BITS-1:0] wb_addr_q [2];
    logic [1:0]           wb_cnt_q, wb_cnt_d;
    logic                 wb_rd_q, wb_rd_d, wb_wr_q, wb_wr_d;
    logic                 in_valid, in_ready, out_valid, out_ready;
    logic [7:0]           in_data;
    logic [ADDR_BITS-1:0] in_addr;
    assign in_ready  = wb_cnt_q != 2'd2;
    assign out_valid = wb_cnt_q != 2'd0;
    assign out_ready = 1'b1;  // array port never stalls: no busy period
    always_comb begin
        wb_cnt_d = wb_cnt_q;
        wb_rd_d  = wb_rd_q;
        wb_wr_d  = wb_wr_q;
        if (in_valid && in_ready) begin
            wb_wr_d  = ~wb_wr_q;
            wb_cnt_d = wb_cnt_d + 2'd1;
        end
        if (out_valid && out_ready) begin
            wb_rd_d  = ~wb_rd_q;
            wb_cnt_d = wb_cnt_d - 2'd1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_cnt_q <= 2'd0;
            wb_rd_q  <= 1'b0;
            wb_wr_q  <= 1'b0;
        end else begin
            wb_cnt_q <= wb_cnt_d;
            wb_rd_q  <= wb_rd_d;
            wb_wr_q  <= wb_wr_d;
        end
    end
    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            wb_data_q[wb_wr_q] <= in_data;
            wb_addr_q[wb_wr_q] <= in_addr;
        end
        if (out_valid && out_ready) begin
            mem[wb_addr_q[wb_rd_q]] <= wb_data_q[wb_rd_q];
        end
    end
    // command engine
    spimem_pkg::spimem_state_type st_q, st_d;
    spimem_pkg::spimem_power_type pw_q, pw_d;
    logic [7:0]           sh_q, sh_d, out_q, out_d;
    logic [2:0]           bit_q, bit_d;
    logic [15:0]          adr_q, adr_d;
    logic                 adr_hi_q, adr_hi_d, wr_op_q, wr_op_d;
    logic [7:0]           op_q, op_d;
    logic                 wel_q, wel_d, so_q, so_d, oe_q, oe_d;
    logic [7:0]           stat_q, stat_d;
    logic [CW-1:0]        tmr_q, tmr_d;
    logic [7:0]           byte_in, status_view;
    logic [ADDR_BITS-1:0] cur;
    logic                 byte_done, prot, stat_ok;
    assign byte_in     = {sh_q[6:0], si_s};
    assign byte_done   = rise && bit_q == 3'd7;
    assign cur         = adr_q[ADDR_BITS-1:0];  // top address bit dropped
    // bit 0 is stored as written, never set by hardware
    assign status_view = {stat_q[7:2], wel_q, stat_q[0]};
    always_comb begin
        unique case ({stat_q[`SPIMEM_BIT_BPHI], stat_q[`SPIMEM_BIT_BPLO]})
            2'b00: prot = 1'b0;
            2'b01: prot = cur[ADDR_BITS-1] & cur[ADDR_BITS-2];
            2'b10: prot = cur[ADDR_BITS-1];
            2'b11: prot = 1'b1;
        endcase
    end
    // protect bit set means wp low blocks the status write
    assign stat_ok = wel_q && !(stat_q[`SPIMEM_BIT_SWP] && !wp_s);
    assign in_valid = st_q == spimem_pkg::SPIMEM_ST_WDATA && byte_done && wel_q && !prot;
    assign in_data  = byte_in;
    assign in_addr  = cur;
    always_comb begin
        st_d     = st_q;
        pw_d     = pw_q;
        sh_d     = sh_q;
        out_d    = out_q;
        bit_d    = bit_q;
        adr_d    = adr_q;
        adr_hi_d = adr_hi_q;
        wr_op_d  = wr_op_q;
        op_d     = op_q;
        wel_d    = wel_q;
        stat_d   = stat_q;
        so_d     = so_q;
        oe_d     = oe_q;
        tmr_d    = tmr_q;
        if (tmr_q != '0) begin
            tmr_d = tmr_q - CW'(1);
        end else if (pw_q == spimem_pkg::SPIMEM_PW_ENTER) begin
            pw_d = spimem_pkg::SPIMEM_PW_ASLEEP;
        end else if (pw_q == spimem_pkg::SPIMEM_PW_WAKING) begin
            pw_d = spimem_pkg::SPIMEM_PW_AWAKE;
        end
        if (rise) begin
            sh_d  = byte_in;
            bit_d = bit_q + 3'd1;
        end
        if (cs_fall) begin
            st_d  = spimem_pkg::SPIMEM_ST_OPCODE;
            bit_d = 3'd0;
        end
        if (fall && oe_q) begin
            so_d  = out_q[7];
            out_d = {out_q[6:0], 1'b0};
        end
        if (byte_done) begin
            unique case (st_q)
                spimem_pkg::SPIMEM_ST_OPCODE: begin
                    op_d     = byte_in;
                    adr_hi_d = 1'b1;
                    st_d     = spimem_pkg::SPIMEM_ST_IGNORE;
                    if (pw_q == spimem_pkg::SPIMEM_PW_ASLEEP) begin
                        // only wake acts; others leave state and output alone
                        if (byte_in == `SPIMEM_OP_WAKE_CODE) begin
                            op_d = byte_in;
                        end else begin
                            op_d = 8'h00;
                        end
                    end else if (pw_q != spimem_pkg::SPIMEM_PW_AWAKE) begin
                        op_d = 8'h00;
                    end else begin
                        unique case (byte_in)
                            `SPIMEM_OP_WRITE_ENABLE_CMD_CODE: wel_d = 1'b1;
                            `SPIMEM_OP_WRITE_DISABLE_CMD_CODE: wel_d = 1'b0;
                            `SPIMEM_OP_RDSTAT_CODE: begin
                                st_d  = spimem_pkg::SPIMEM_ST_STAT;
                                out_d = status_view;
                                oe_d  = 1'b1;
                            end
                            `SPIMEM_OP_WRSTAT_CODE: st_d = spimem_pkg::SPIMEM_ST_SDATA;
                            `SPIMEM_OP_READ_CODE, `SPIMEM_OP_WRITE_CODE: begin
                                st_d    = spimem_pkg::SPIMEM_ST_ADDR;
                                wr_op_d = byte_in == `SPIMEM_OP_WRITE_CODE;
                            end
                            default: st_d = spimem_pkg::SPIMEM_ST_IGNORE;
                        endcase
                    end
                end
                spimem_pkg::SPIMEM_ST_ADDR: begin
                    adr_hi_d = 1'b0;
                    if (adr_hi_q) begin
                        adr_d[15:8] = byte_in;
                    end else begin
                        adr_d[7:0] = byte_in;
                        if (wr_op_q) begin
                            st_d = spimem_pkg::SPIMEM_ST_WDATA;
                        end else begin
                            st_d  = spimem_pkg::SPIMEM_ST_RDATA;
                            out_d = mem[{adr_q[ADDR_BITS-1:8], byte_in}];
                            oe_d  = 1'b1;
                        end
                    end
                end
                spimem_pkg::SPIMEM_ST_RDATA: begin
                    // counter wraps across the top of the array
                    adr_d = {1'b0, ADDR_BITS'(cur + 1'b1)};
                    out_d = mem[ADDR_BITS'(cur + 1'b1)];
                end
                spimem_pkg::SPIMEM_ST_WDATA: begin
                    adr_d = {1'b0, ADDR_BITS'(cur + 1'b1)};
                end
                spimem_pkg::SPIMEM_ST_SDATA: begin
                    if (stat_ok) begin
                        stat_d = byte_in;
                    end
                    st_d = spimem_pkg::SPIMEM_ST_IGNORE;  // one byte only
                end
                spimem_pkg::SPIMEM_ST_STAT: begin
                    out_d = status_view;
                end
                spimem_pkg::SPIMEM_ST_IGNORE: begin
                end
                default: st_d = spimem_pkg::SPIMEM_ST_IGNORE;
            endcase
        end
        if (cs_rise) begin
            oe_d = 1'b0;
            st_d = spimem_pkg::SPIMEM_ST_IGNORE;
            // sleep and wake act once the frame closes
            if (pw_q == spimem_pkg::SPIMEM_PW_AWAKE && op_q == `SPIMEM_OP_SLEEP_CODE) begin
                pw_d  = spimem_pkg::SPIMEM_PW_ENTER;
                tmr_d = CW'(ENTRY_CYCLES);
            end else if (pw_q == spimem_pkg::SPIMEM_PW_ASLEEP && op_q == `SPIMEM_OP_WAKE_CODE) begin
                pw_d  = spimem_pkg::SPIMEM_PW_WAKING;
                tmr_d = CW'(EXIT_CYCLES);
            end
            op_d = 8'h00;
        end
        if (wel_q == 1'b1 && st_q == spimem_pkg::SPIMEM_ST_SDATA && byte_done && !stat_ok) begin
            stat_d = stat_q;  // refused status write leaves bits alone
        end
    end
    // reset stands for power up: latch clear, awake, not sleeping
    // status bits model nonvolatile cells and only reset to their factory value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q     <= spimem_pkg::SPIMEM_ST_IGNORE;
            pw_q     <= spimem_pkg::SPIMEM_PW_AWAKE;
            sh_q     <= 8'h00;
            out_q    <= 8'h00;
            bit_q    <= 3'd0;
            adr_q    <= 16'h0000;
            adr_hi_q <= 1'b0;
            wr_op_q  <= 1'b0;
            op_q     <= 8'h00;
            wel_q    <= 1'b0;
            stat_q   <= `SPIMEM_STATUS_RESET;
            so_q     <= 1'b1;
            oe_q     <= 1'b0;
            tmr_q    <= '0;
        end else begin
            st_q     <= st_d;
            pw_q     <= pw_d;
            sh_q     <= sh_d;
            out_q    <= out_d;
            bit_q    <= bit_d;
            adr_q    <= adr_d;
            adr_hi_q <= adr_hi_d;
            wr_op_q  <= wr_op_d;
            op_q     <= op_d;
            wel_q    <= wel_d;
            stat_q   <= stat_d;
            so_q     <= so_d;
            oe_q     <= oe_d;
            tmr_q    <= tmr_d;
        end
    end
    logic reg_on_q, ready_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_on_q <= 1'b1;
            ready_q  <= 1'b1;
        end else begin
            reg_on_q <= pw_d != spimem_pkg::SPIMEM_PW_ASLEEP;
            ready_q  <= pw_d == spimem_pkg::SPIMEM_PW_AWAKE;
        end
    end
    assign so_out        = so_q;
    assign so_oe         = oe_q;
    assign regulators_on = reg_on_q;
    assign ready         = ready_q;
endmodule

// ---- bench/spimem_chk.sv ----
// pin-level assertions for the serial memory command block
`timescale 1ns/1ps
module spimem_chk #(
    parameter int ENTRY_CYCLES = 75,
    parameter int EXIT_CYCLES  = 10000
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic wp_n,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic regulators_on,
    input wire logic ready
);
    // slack covers the pin synchronisers
    localparam int ENT_HI  = ENTRY_CYCLES + 8;
    localparam int EXIT_HI = EXIT_CYCLES + 8;
    // cycles spent powered but not ready; a counter, as exit spans run long
    logic [15:0] rec_cnt_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rec_cnt_q <= 16'h0000;
        end else if (regulators_on && !ready) begin
            rec_cnt_q <= rec_cnt_q + 16'h0001;
        end else begin
            rec_cnt_q <= 16'h0000;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    AST_OFF_NOT_READY: assert property (!regulators_on |-> !ready)
        else $error("ready high with regulators off");
    AST_ENTRY_DONE: assert property ($fell(ready) |-> ##[1:ENT_HI] !regulators_on)
        else $error("regulators still on after sleep entry");
    AST_ENTRY_MIN: assert property ($fell(ready) |-> regulators_on[*3])
        else $error("regulators dropped before entry time");
    AST_WAKE_DONE: assert property (rec_cnt_q <= EXIT_HI)
        else $error("ready not back after wake");
    AST_ENTRY_LONG: assert property ($fell(regulators_on) |-> rec_cnt_q >= ENTRY_CYCLES)
        else $error("sleep entry shorter than entry time");
    AST_WAKE_LONG: assert property ($rose(ready) |-> rec_cnt_q >= EXIT_CYCLES)
        else $error("wake recovery shorter than exit time");
    AST_WAKE_MIN: assert property ($rose(regulators_on) |-> !ready[*8])
        else $error("ready back before exit time");
    AST_SLEEP_QUIET: assert property (!regulators_on |-> !so_oe)
        else $error("output driven while asleep");
    AST_RECOVERY_QUIET: assert property (!ready |-> !so_oe)
        else $error("output driven while not ready");
    AST_DRIVE_IN_FRAME: assert property ($rose(so_oe) |-> !cs_n)
        else $error("output enabled outside a frame");
    AST_RELEASE: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
        else $error("output not released after deselect");
    AST_HOLD_HIGH: assert property (sck[*6] ##0 so_oe |-> $stable(so_out))
        else $error("output moved while clock high");
    AST_SLEEP_ON_DESELECT: assert property ($fell(ready) |-> cs_n)
        else $error("sleep began inside a frame");
endmodule
bind spimem_core spimem_chk #(
    .ENTRY_CYCLES(ENTRY_CYCLES), .EXIT_CYCLES(EXIT_CYCLES)
) chk_u (
    .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so_out(so_out), .so_oe(so_oe), .regulators_on(regulators_on), .ready(ready)
);

// ---- bench/spimem_host.sv ----
// mode 0 spi host model for the serial memory
`timescale 1ns/1ps
module spimem_host (
    input  wire logic clk,
    input  wire logic so_out,
    output logic      cs_n,
    output logic      sck,
    output logic      si
);
    // half period of 6 clocks, margin over the 3 clock sampler
    localparam int HALF = 6;
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // msb first, read bit taken just before the rise
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            wait_clk(HALF);
            rx[i] = so_out;
            sck <= 1'b1;
            wait_clk(HALF);
            sck <= 1'b0;
        end
    endtask
    // one command per select frame
    task automatic open_frame();
        cs_n <= 1'b0;
        wait_clk(HALF);
    endtask
    // frames end on a byte boundary, select high between them
    task automatic close_frame();
        wait_clk(HALF);
        cs_n <= 1'b1;
        si   <= ~si;
        wait_clk(HALF);
    endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the serial memory command block
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic reset_n;
    logic wp_n;
    logic cs_n;
    logic sck;
    logic si;
    logic so_out;
    logic so_oe;
    logic regulators_on;
    logic ready;
    int   err_count;
    int   checks;
    // short sleep counts keep the run brief
    localparam int SIM_ENTRY = 4;
    localparam int SIM_EXIT  = 20;
    logic so_line;
    always #20 clk = ~clk;
    // released output floats to its pull-up, never the last bit shifted
    assign so_line = so_oe ? so_out : 1'b1;
    spimem_core #(.ENTRY_CYCLES(SIM_ENTRY), .EXIT_CYCLES(SIM_EXIT)) dut_u (
        .clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
        .so_out(so_out), .so_oe(so_oe), .regulators_on(regulators_on), .ready(ready));
    spimem_host host_u (.clk(clk), .so_out(so_line), .cs_n(cs_n), .sck(sck), .si(si));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pwr(input logic [7:0] exp);
        @(negedge clk);
        check("power", exp, {6'h00, regulators_on, ready});
        @(posedge clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        host_u.open_frame();
        host_u.xbyte(op, r);
        host_u.close_frame();
    endtask
    task automatic status_read_cmd(output logic [7:0] s);
        logic [7:0] r;
        host_u.open_frame();
        host_u.xbyte(8'h05, r);
        host_u.xbyte(8'h00, s);
        host_u.close_frame();
    endtask
    task automatic status_write_cmd(input logic [7:0] v);
        logic [7:0] r;
        cmd(8'h06);
        host_u.open_frame();
        host_u.xbyte(8'h01, r);
        host_u.xbyte(v, r);
        host_u.close_frame();
    endtask
    task automatic wr(input logic en, input logic [15:0] a, input logic [7:0] d[$]);
        logic [7:0] r;
        if (en) cmd(8'h06);
        host_u.open_frame();
        host_u.xbyte(8'h02, r);
        host_u.xbyte(a[15:8], r);
        host_u.xbyte(a[7:0], r);
        foreach (d[i]) host_u.xbyte(d[i], r);
        host_u.close_frame();
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e[$]);
        logic [7:0] r;
        host_u.open_frame();
        host_u.xbyte(8'h03, r);
        host_u.xbyte(a[15:8], r);
        host_u.xbyte(a[7:0], r);
        foreach (e[i]) begin
            host_u.xbyte(8'h00, r);
            check("read data", e[i], r);
        end
        host_u.close_frame();
    endtask
    task automatic test_latch();
        logic [7:0] s;
        status_read_cmd(s);
        check("status at reset", 8'h00, s);
        cmd(8'h06);
        status_read_cmd(s);
        check("latch set", 8'h02, s);
        wr(1'b1, 16'h0010, '{8'ha5, 8'h3c});
        cmd(8'h04);
        status_read_cmd(s);
        check("latch clear", 8'h00, s);
        wr(1'b0, 16'h0010, '{8'hff});
        rd(16'h0010, '{8'ha5, 8'h3c});
        $display("test latch done");
    endtask
    task automatic test_wrap();
        wr(1'b1, 16'hfffe, '{8'h11, 8'h22, 8'h33, 8'h44});
        wr(1'b1, 16'h0100, '{8'h5a});
        rd(16'h7fff, '{8'h22, 8'h33, 8'h44});
        rd(16'h8100, '{8'h5a});
        $display("test wrap done");
    endtask
    task automatic test_status();
        logic [7:0] s;
        status_write_cmd(8'h8d);
        status_read_cmd(s);
        check("status written", 8'h8d, s & 8'hfd);
        wp_n <= 1'b0;
        status_write_cmd(8'h00);
        status_read_cmd(s);
        check("status locked", 8'h8d, s & 8'hfd);
        wr(1'b1, 16'h0010, '{8'h00});
        rd(16'h0010, '{8'ha5});
        wp_n <= 1'b1;
        status_write_cmd(8'h04);
        wr(1'b1, 16'h7ffe, '{8'hee});
        wr(1'b1, 16'h0011, '{8'h44});
        rd(16'h7ffe, '{8'h11});
        rd(16'h0011, '{8'h44});
        status_write_cmd(8'h00);
        wr(1'b1, 16'h4000, '{8'h66});
        status_write_cmd(8'h08);
        wr(1'b1, 16'h4000, '{8'h77});
        wr(1'b1, 16'h3fff, '{8'h55});
        rd(16'h3fff, '{8'h55, 8'h66});
        status_write_cmd(8'h00);
        $display("test status done");
    endtask
    task automatic test_sleep();
        logic [7:0] s;
        int         n;
        cmd(8'h04);
        cmd(8'hb9);
        pwr(8'h02);
        host_u.wait_clk(12);
        pwr(8'h00);
        cmd(8'h06);
        status_read_cmd(s);
        check("status asleep", 8'hff, s);
        cmd(8'hab);
        for (n = 0; n < 200 && ready !== 1'b1; n++) @(negedge clk);
        // select held high all through recovery; six cycles already spent closing
        check("wake wait", 8'h01, {7'h00, n >= SIM_EXIT - 6});
        pwr(8'h03);
        status_read_cmd(s);
        check("latch after sleep", 8'h00, s & 8'h02);
        cmd(8'h06);
        cmd(8'hb9);
        host_u.wait_clk(12);
        reset_n <= 1'b0;
        host_u.wait_clk(2);
        reset_n <= 1'b1;
        host_u.wait_clk(3);
        pwr(8'h03);
        status_read_cmd(s);
        check("latch after reset", 8'h00, s & 8'h02);
        $display("test sleep done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk       = 1'b0;
        reset_n   = 1'b0;
        wp_n      = 1'b1;
        err_count = 0;
        checks    = 0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_latch();
        test_wrap();
        test_status();
        test_sleep();
        stop_test();
    end
    // about 13200 cycles expected
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        stop_test();
    end
endmodule
